// ---- verilog/wdt_event_mgr.sv ----
// Design decisions made here: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/100ps
// Summary of operation
// - when the first stage counts its programmed timeout down, a management-mode interrupt pulses.
// - the second stage starts only from expiry of the first and never runs alone.
// - the second stage has a fixed length and on expiry requests a system reset.
// - the no-reboot control bit suppresses the reset request from the second stage.
// - host error events route to any mix of management, control, system-error and unit interrupts.
// - an asserted intruder input raises the unit interrupt or the management interrupt as set.
// - console messages go out on intruder on, watchdog expiry, both alert edges, both battery edges, power fail on.
// - in compatible mode only the host SMBus carries management traffic.
// - in compatible mode the unit target sits on the host SMBus by default.
// - advanced mode enables both management links and lets the target move to link zero.
// - the fast-mode bit lets link zero run up to 1 MHz, and a faster clock is flagged.
// - firmware sets the phy-present bit and the block reports link zero as holding the phy.
// - sensor hub pins stay undriven in reset, after reset and in deep sleep.
// - with a baseboard controller on link one, the host and unit target reach it over SMBus.
module wdt_event_mgr #(
	parameter int unsigned TICK_CYCLES = wdt_event_pkg::WD_TICK_CYCLES,
	parameter int unsigned SECOND_TICKS = wdt_event_pkg::SECOND_STAGE_TICKS,
	parameter int HUB_PINS = 8
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// event pins
	input wire logic intruder_n_i,
	input wire logic smbus_alert_n_i,
	input wire logic battery_low_in_n_i,
	input wire logic power_failure_event_i,
	input wire logic deep_sleep_i,
	input wire logic mgmt_link_zero_clk_i,
	// host error, same clock
	input wire logic host_error_i,
	// interrupts and reset
	output logic mgmt_mode_interrupt_o,
	output logic control_interrupt_o,
	output logic system_error_signal_o,
	output logic management_watchdog_unit_irq_o,
	output logic system_reset_req_o,
	// console messages
	output logic msg_valid_o,
	output logic [2:0] msg_code_o,
	// link routing
	output logic target_on_host_o,
	output logic target_on_link_zero_o,
	output logic mgmt_link_zero_en_o,
	output logic mgmt_link_one_en_o,
	output logic link_zero_fast_o,
	output logic link_zero_phy_o,
	// sensor hub pins
	output logic [HUB_PINS-1:0] sensor_hub_out_o,
	output logic [HUB_PINS-1:0] sensor_hub_oe_o
);
	localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);
	localparam logic [7:0] SECOND_LAST = 8'(SECOND_TICKS - 1);

	// ------------------------------------------------------------
	// pin synchronisers and edges
	// ------------------------------------------------------------
	logic [5:0] pins_s;
	logic intr_fall, alert_rise, alert_fall, bat_rise, bat_fall, pf_rise, lclk_rise;
	logic unused_intr_rise, unused_pf_fall, unused_lclk_fall;

	sync2 #(.WIDTH(6), .INIT(6'h17)) u_sync ( // idle levels, no false edge at release
		.clk_i(clk_i),
		.rst_i(rst_i),
		.async_i({deep_sleep_i, mgmt_link_zero_clk_i, power_failure_event_i,
			battery_low_in_n_i, smbus_alert_n_i, intruder_n_i}),
		.sync_o(pins_s)
	);
	edge_find #(.IDLE(1'b1)) u_intr (.clk_i(clk_i), .rst_i(rst_i), .level_i(pins_s[0]),
		.rise_o(unused_intr_rise), .fall_o(intr_fall));
	edge_find #(.IDLE(1'b1)) u_alert (.clk_i(clk_i), .rst_i(rst_i), .level_i(pins_s[1]),
		.rise_o(alert_rise), .fall_o(alert_fall));
	edge_find #(.IDLE(1'b1)) u_bat (.clk_i(clk_i), .rst_i(rst_i), .level_i(pins_s[2]),
		.rise_o(bat_rise), .fall_o(bat_fall));
	edge_find #(.IDLE(1'b0)) u_pf (.clk_i(clk_i), .rst_i(rst_i), .level_i(pins_s[3]),
		.rise_o(pf_rise), .fall_o(unused_pf_fall));
	edge_find #(.IDLE(1'b1)) u_lclk (.clk_i(clk_i), .rst_i(rst_i), .level_i(pins_s[4]),
		.rise_o(lclk_rise), .fall_o(unused_lclk_fall));

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic [12:0] ctrl, next_ctrl;
	logic [15:0] timeout, next_timeout;
	logic [15:0] count, next_count;
	logic [7:0] second, next_second;
	logic [31:0] prescale, next_prescale;
	wdt_event_pkg::wd_state_t wd_state, next_wd_state;
	logic [4:0] status, next_status;
	logic [15:0] lcnt, next_lcnt;
	logic [15:0] lperiod, next_lperiod;
	logic [HUB_PINS-1:0] hub_out, next_hub_out;
	logic [wdt_event_pkg::MSG_COUNT-1:0] pend, next_pend;
	logic [31:0] next_dat;
	logic next_ack;
	logic next_smi, next_sci, next_system_error_signal, next_wdu, next_rst_req;
	logic next_msg_valid;
	logic [2:0] next_msg_code;
	logic next_hub_gate;
	logic hub_gate;

	logic wr, rd_hit, reload_wr, first_fire, second_fire, tick;
	logic [15:0] min_cyc;
	logic [wdt_event_pkg::MSG_COUNT-1:0] msg_set;
	logic [31:0] wmask;

	always_comb begin
		wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
		wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
		reload_wr = wr & (wb_adr_i == wdt_event_pkg::OFS_RELOAD);
		next_ctrl = ctrl;
		next_timeout = timeout;
		next_hub_out = hub_out;
		if (wr && wb_adr_i == wdt_event_pkg::OFS_CTRL) begin
			next_ctrl = (ctrl & ~wmask[12:0]) | (wb_dat_i[12:0] & wmask[12:0]);
		end
		if (wr && wb_adr_i == wdt_event_pkg::OFS_TIMEOUT) begin
			next_timeout = (timeout & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
		end
		if (wr && wb_adr_i == wdt_event_pkg::OFS_HUB_OUT) begin
			next_hub_out = (hub_out & ~wmask[HUB_PINS-1:0]) |
				(wb_dat_i[HUB_PINS-1:0] & wmask[HUB_PINS-1:0]);
		end

		// --------------------------------------------------------
		// two-stage watchdog
		// --------------------------------------------------------
		tick = (prescale == TICK_LAST);
		next_prescale = tick ? 32'h0000_0000 : prescale + 32'h0000_0001;
		next_count = count;
		next_second = second;
		next_wd_state = wd_state;
		first_fire = 1'b0;
		second_fire = 1'b0;
		if (!ctrl[wdt_event_pkg::CTL_WD_ENABLE]) begin
			next_wd_state = wdt_event_pkg::WD_IDLE;
			next_prescale = 32'h0000_0000;
		end else if (reload_wr || wd_state == wdt_event_pkg::WD_IDLE) begin
			next_wd_state = wdt_event_pkg::WD_FIRST;
			next_count = timeout;
			next_second = SECOND_LAST;
			next_prescale = 32'h0000_0000;
		end else if (tick) begin
			case (wd_state)
				wdt_event_pkg::WD_FIRST: begin
					if (count == 16'h0000) begin
						first_fire = 1'b1;
						next_wd_state = wdt_event_pkg::WD_SECOND;
						next_second = SECOND_LAST;
					end else begin
						next_count = count - 16'h0001;
					end
				end
				wdt_event_pkg::WD_SECOND: begin
					if (second == 8'h00) begin
						second_fire = 1'b1;
						next_wd_state = wdt_event_pkg::WD_DONE;
					end else begin
						next_second = second - 8'h01;
					end
				end
				default: begin
					next_wd_state = wd_state;
				end
			endcase
		end
		// reboot request held off by the no-reboot bit
		next_rst_req = second_fire & ~ctrl[wdt_event_pkg::CTL_NO_REBOOT];

		// --------------------------------------------------------
		// event routing
		// --------------------------------------------------------
		next_smi = first_fire |
			(host_error_i & ctrl[wdt_event_pkg::CTL_ERR_SMI]) |
			(intr_fall & ctrl[wdt_event_pkg::CTL_INTRUDER_SMI]);
		next_sci = host_error_i & ctrl[wdt_event_pkg::CTL_ERR_SCI];
		next_system_error_signal = host_error_i & ctrl[wdt_event_pkg::CTL_ERR_SYSTEM_ERROR_SIGNAL];
		next_wdu = (host_error_i & ctrl[wdt_event_pkg::CTL_ERR_WDU]) |
			(intr_fall & ~ctrl[wdt_event_pkg::CTL_INTRUDER_SMI]);

		// --------------------------------------------------------
		// link zero clock rate
		// --------------------------------------------------------
		// link clock may stop between frames, so only a short period counts
		min_cyc = ctrl[wdt_event_pkg::CTL_LINK0_FAST] ? wdt_event_pkg::LINK0_FAST_MIN_CYC :
			wdt_event_pkg::LINK0_STD_MIN_CYC;
		next_lcnt = (lcnt == 16'hffff) ? lcnt : lcnt + 16'h0001;
		next_lperiod = lperiod;
		if (lclk_rise) begin
			next_lcnt = 16'h0001;
			next_lperiod = lcnt;
		end

		// --------------------------------------------------------
		// sticky status, set wins over clear
		// --------------------------------------------------------
		next_status = status;
		if (wr && wb_adr_i == wdt_event_pkg::OFS_STATUS && wb_sel_i[0]) begin
			next_status = status & ~wb_dat_i[4:0];
		end
		if (first_fire) next_status[wdt_event_pkg::ST_FIRST_EXP] = 1'b1;
		if (second_fire) next_status[wdt_event_pkg::ST_SECOND_EXP] = 1'b1;
		if (intr_fall) next_status[wdt_event_pkg::ST_INTRUDER] = 1'b1;
		if (host_error_i) next_status[wdt_event_pkg::ST_ERROR] = 1'b1;
		if (lclk_rise && lcnt < min_cyc) next_status[wdt_event_pkg::ST_OVERSPEED] = 1'b1;

		// --------------------------------------------------------
		// console messages, lowest code first
		// --------------------------------------------------------
		msg_set = '0;
		msg_set[wdt_event_pkg::MSG_INTRUDER_ON] = intr_fall;
		msg_set[wdt_event_pkg::MSG_WATCHDOG] = first_fire;
		msg_set[wdt_event_pkg::MSG_ALERT_ON] = alert_fall;
		msg_set[wdt_event_pkg::MSG_ALERT_OFF] = alert_rise;
		msg_set[wdt_event_pkg::MSG_BATTERY_LOW_IN_ON] = bat_fall;
		msg_set[wdt_event_pkg::MSG_BATTERY_LOW_IN_OFF] = bat_rise;
		msg_set[wdt_event_pkg::MSG_POWER_FAIL] = pf_rise;
		next_pend = pend;
		next_msg_valid = 1'b0;
		next_msg_code = 3'h0;
		for (int i = wdt_event_pkg::MSG_COUNT - 1; i >= 0; i--) begin
			if (pend[i]) begin
				next_msg_valid = 1'b1;
				next_msg_code = 3'(i);
			end
		end
		if (next_msg_valid) next_pend[next_msg_code] = 1'b0;
		next_pend = next_pend | msg_set;

		// --------------------------------------------------------
		// hub pins: gate opens a cycle after enable, never in sleep
		// --------------------------------------------------------
		next_hub_gate = ctrl[wdt_event_pkg::CTL_HUB_ENABLE] & ~pins_s[5];

		// --------------------------------------------------------
		// bus answer; unmapped reads zero, writes dropped
		// --------------------------------------------------------
		next_ack = wb_cyc_i & wb_stb_i & ~wb_ack_o;
		rd_hit = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;
		next_dat = 32'h0000_0000;
		if (rd_hit) begin
			case (wb_adr_i)
				wdt_event_pkg::OFS_CTRL: next_dat = {19'h00000, ctrl};
				wdt_event_pkg::OFS_TIMEOUT: next_dat = {16'h0000, timeout};
				wdt_event_pkg::OFS_RELOAD: next_dat = {8'h00, second, count};
				wdt_event_pkg::OFS_STATUS: next_dat = {22'h000000, wd_state, 3'h0, status};
				wdt_event_pkg::OFS_LINK0_PERIOD: next_dat = {16'h0000, lperiod};
				wdt_event_pkg::OFS_HUB_OUT: next_dat = 32'(hub_out);
				default: next_dat = 32'h0000_0000;
			endcase
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ctrl <= wdt_event_pkg::CTRL_RESET;
			timeout <= wdt_event_pkg::TIMEOUT_RESET;
			count <= wdt_event_pkg::TIMEOUT_RESET;
			second <= 8'h00;
			prescale <= 32'h0000_0000;
			wd_state <= wdt_event_pkg::WD_IDLE;
			status <= 5'h00;
			lcnt <= 16'hffff;
			lperiod <= 16'h0000;
			hub_out <= '0;
			hub_gate <= 1'b0;
			pend <= '0;
			wb_dat_o <= 32'h0000_0000;
			wb_ack_o <= 1'b0;
			mgmt_mode_interrupt_o <= 1'b0;
			control_interrupt_o <= 1'b0;
			system_error_signal_o <= 1'b0;
			management_watchdog_unit_irq_o <= 1'b0;
			system_reset_req_o <= 1'b0;
			msg_valid_o <= 1'b0;
			msg_code_o <= 3'h0;
			target_on_host_o <= 1'b1;
			target_on_link_zero_o <= 1'b0;
			mgmt_link_zero_en_o <= 1'b0;
			mgmt_link_one_en_o <= 1'b0;
			link_zero_fast_o <= 1'b0;
			link_zero_phy_o <= 1'b0;
			sensor_hub_out_o <= '0;
			sensor_hub_oe_o <= '0;
		end else begin
			ctrl <= next_ctrl;
			timeout <= next_timeout;
			count <= next_count;
			second <= next_second;
			prescale <= next_prescale;
			wd_state <= next_wd_state;
			status <= next_status;
			lcnt <= next_lcnt;
			lperiod <= next_lperiod;
			hub_out <= next_hub_out;
			hub_gate <= next_hub_gate;
			pend <= next_pend;
			wb_dat_o <= next_dat;
			wb_ack_o <= next_ack;
			mgmt_mode_interrupt_o <= next_smi;
			control_interrupt_o <= next_sci;
			system_error_signal_o <= next_system_error_signal;
			management_watchdog_unit_irq_o <= next_wdu;
			system_reset_req_o <= next_rst_req;
			msg_valid_o <= next_msg_valid;
			msg_code_o <= next_msg_code;
			// compatible mode: host bus only, target on it
			target_on_host_o <= ~(ctrl[wdt_event_pkg::CTL_ADVANCED] &
				ctrl[wdt_event_pkg::CTL_TARGET_LINK0]);
			target_on_link_zero_o <= ctrl[wdt_event_pkg::CTL_ADVANCED] &
				ctrl[wdt_event_pkg::CTL_TARGET_LINK0];
			mgmt_link_zero_en_o <= ctrl[wdt_event_pkg::CTL_ADVANCED];
			mgmt_link_one_en_o <= ctrl[wdt_event_pkg::CTL_ADVANCED];
			link_zero_fast_o <= ctrl[wdt_event_pkg::CTL_LINK0_FAST];
			link_zero_phy_o <= ctrl[wdt_event_pkg::CTL_LINK0_PHY];
			sensor_hub_out_o <= hub_gate ? hub_out : '0;
			sensor_hub_oe_o <= {HUB_PINS{hub_gate}};
		end
	end
endmodule

// ---- verilog/wdt_event_pkg.sv ----
package wdt_event_pkg;
	// ------------------------------------------------------------
	// clock
	// ------------------------------------------------------------
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned LINK0_FAST_MAX_HZ = 1_000_000;
	localparam int unsigned LINK0_STD_MAX_HZ = 100_000;
	localparam logic [15:0] LINK0_FAST_MIN_CYC =
		16'((CLK_HZ + LINK0_FAST_MAX_HZ - 1) / LINK0_FAST_MAX_HZ);
	localparam logic [15:0] LINK0_STD_MIN_CYC =
		16'((CLK_HZ + LINK0_STD_MAX_HZ - 1) / LINK0_STD_MAX_HZ);
	localparam int unsigned WD_TICK_CYCLES = 100_000;
	localparam int unsigned SECOND_STAGE_TICKS = 4;

	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_TIMEOUT = 8'h04;
	localparam logic [7:0] OFS_RELOAD = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0c;
	localparam logic [7:0] OFS_LINK0_PERIOD = 8'h10;
	localparam logic [7:0] OFS_HUB_OUT = 8'h14;

	// ------------------------------------------------------------
	// control fields
	// ------------------------------------------------------------
	localparam int CTL_ADVANCED = 0;
	localparam int CTL_TARGET_LINK0 = 1;
	localparam int CTL_LINK0_FAST = 2;
	localparam int CTL_LINK0_PHY = 3;
	localparam int CTL_NO_REBOOT = 4;
	localparam int CTL_WD_ENABLE = 5;
	localparam int CTL_INTRUDER_SMI = 6;
	localparam int CTL_ERR_SMI = 8;
	localparam int CTL_ERR_SCI = 9;
	localparam int CTL_ERR_SYSTEM_ERROR_SIGNAL = 10;
	localparam int CTL_ERR_WDU = 11;
	localparam int CTL_HUB_ENABLE = 12;
	localparam logic [12:0] CTRL_RESET = 13'h0000;
	localparam logic [15:0] TIMEOUT_RESET = 16'h0010;

	// ------------------------------------------------------------
	// status fields (flags write one to clear, stage field read only)
	// ------------------------------------------------------------
	localparam int ST_FIRST_EXP = 0;
	localparam int ST_SECOND_EXP = 1;
	localparam int ST_INTRUDER = 2;
	localparam int ST_ERROR = 3;
	localparam int ST_OVERSPEED = 4;
	localparam int ST_STAGE_LSB = 8;

	// ------------------------------------------------------------
	// message codes
	// ------------------------------------------------------------
	localparam int MSG_COUNT = 7;
	localparam int MSG_INTRUDER_ON = 0;
	localparam int MSG_WATCHDOG = 1;
	localparam int MSG_ALERT_ON = 2;
	localparam int MSG_ALERT_OFF = 3;
	localparam int MSG_BATTERY_LOW_IN_ON = 4;
	localparam int MSG_BATTERY_LOW_IN_OFF = 5;
	localparam int MSG_POWER_FAIL = 6;

	typedef enum logic [1:0] {WD_IDLE, WD_FIRST, WD_SECOND, WD_DONE} wd_state_t;
endpackage

// ---- verilog/sync2.sv ----
`timescale 1ns/100ps
module sync2 #(
	parameter int WIDTH = 1,
	// reset to the pins' idle levels so release shows no edge
	parameter logic [WIDTH-1:0] INIT = '0
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// levels
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] stage1;

	// ------------------------------------------------------------
	// two flops; only the second reads the first
	// ------------------------------------------------------------
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			stage1 <= INIT;
			sync_o <= INIT;
		end else begin
			stage1 <= async_i;
			sync_o <= stage1;
		end
	end
endmodule

// ---- verilog/edge_find.sv ----
`timescale 1ns/100ps
module edge_find #(
	parameter logic IDLE = 1'b0
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// level and its edges
	input wire logic level_i,
	output logic rise_o,
	output logic fall_o
);
	logic last;

	// idle level preset so reset release gives no false edge
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			last <= IDLE;
		end else begin
			last <= level_i;
		end
	end

	assign rise_o = level_i & ~last;
	assign fall_o = ~level_i & last;
endmodule

// ---- verif/link_partner.sv ----
`timescale 1ns/100ps
module link_partner #(
	parameter realtime HALF = 40.0
) (
	// frame control
	input wire logic run_i,
	// link clock
	output logic clk_o
);
	// ------------------------------------------------------------
	// link clock, still and pulled high outside frames
	// ------------------------------------------------------------
	initial begin
		clk_o = 1'b1;
		forever begin
			if (run_i) begin
				#HALF clk_o = ~clk_o;
			end else begin
				clk_o = 1'b1;
				@(run_i);
				// offset keeps link edges clear of the bench clock edges
				#3;
			end
		end
	end
endmodule

// ---- verif/wdt_event_mgr_asserts.sv ----
`timescale 1ns/100ps
module wdt_event_mgr_chk #(
	parameter int unsigned TICK_CYCLES = 4,
	parameter int unsigned SECOND_TICKS = 2,
	parameter int HUB_PINS = 8
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// inputs watched
	input wire logic intruder_n_i,
	input wire logic deep_sleep_i,
	input wire logic host_error_i,
	// interrupts and messages
	input wire logic mgmt_mode_interrupt_o,
	input wire logic control_interrupt_o,
	input wire logic system_error_signal_o,
	input wire logic management_watchdog_unit_irq_o,
	input wire logic system_reset_req_o,
	input wire logic msg_valid_o,
	input wire logic [2:0] msg_code_o,
	// routing and hub pins
	input wire logic target_on_host_o,
	input wire logic target_on_link_zero_o,
	input wire logic mgmt_link_zero_en_o,
	input wire logic mgmt_link_one_en_o,
	input wire logic [HUB_PINS-1:0] sensor_hub_out_o,
	input wire logic [HUB_PINS-1:0] sensor_hub_oe_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ------------------------------------------------------------
	// cycles since the last management interrupt, saturating
	// ------------------------------------------------------------
	int gap;
	int next_gap;
	always_comb begin
		next_gap = gap;
		if (mgmt_mode_interrupt_o) begin
			next_gap = 1;
		end else if (gap < 100000) begin
			next_gap = gap + 1;
		end
	end
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			gap <= 100000;
		end else begin
			gap <= next_gap;
		end
	end
	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	property p_sci_cause;
		control_interrupt_o |-> $past(host_error_i);
	endproperty
	a_sci_cause: assert property (p_sci_cause) else $error("control irq without error");
	property p_system_error_signal_cause;
		system_error_signal_o |-> $past(host_error_i);
	endproperty
	a_system_error_signal_cause: assert property (p_system_error_signal_cause) else $error("system_error_signal without error");
	property p_sleep_off;
		deep_sleep_i [*5] |-> sensor_hub_oe_o == '0;
	endproperty
	a_sleep_off: assert property (p_sleep_off) else $error("hub driven in sleep");
	property p_out_gated;
		(|sensor_hub_out_o) |-> (&sensor_hub_oe_o);
	endproperty
	a_out_gated: assert property (p_out_gated) else $error("hub data while undriven");
	property p_compat;
		!mgmt_link_zero_en_o |-> target_on_host_o && !mgmt_link_one_en_o;
	endproperty
	a_compat: assert property (p_compat) else $error("links used in compatible mode");
	property p_target;
		target_on_host_o != target_on_link_zero_o;
	endproperty
	a_target: assert property (p_target) else $error("target on both or neither");
	property p_adv;
		target_on_link_zero_o |-> mgmt_link_zero_en_o && mgmt_link_one_en_o;
	endproperty
	a_adv: assert property (p_adv) else $error("target moved outside advanced");
	property p_intr_irq;
		$fell(intruder_n_i) |-> ##[2:8] (mgmt_mode_interrupt_o || management_watchdog_unit_irq_o);
	endproperty
	a_intr_irq: assert property (p_intr_irq) else $error("intruder raised no irq");
	property p_intr_msg;
		$fell(intruder_n_i) |-> ##[2:12] (msg_valid_o && msg_code_o == 3'h0);
	endproperty
	a_intr_msg: assert property (p_intr_msg) else $error("intruder sent no message");
	property p_reboot;
		system_reset_req_o |-> gap == SECOND_TICKS * TICK_CYCLES;
	endproperty
	a_reboot: assert property (p_reboot) else $error("reset request at wrong time");
	c_reboot: cover property (system_reset_req_o);
	c_wd_msg: cover property (msg_valid_o && msg_code_o == 3'h1);
	c_hub_on: cover property (&sensor_hub_oe_o);
endmodule
bind wdt_event_mgr wdt_event_mgr_chk #(.TICK_CYCLES(TICK_CYCLES), .SECOND_TICKS(SECOND_TICKS),
	.HUB_PINS(HUB_PINS)) i_chk (.clk_i, .rst_i, .intruder_n_i, .deep_sleep_i, .host_error_i,
	.mgmt_mode_interrupt_o, .control_interrupt_o, .system_error_signal_o,
	.management_watchdog_unit_irq_o, .system_reset_req_o, .msg_valid_o, .msg_code_o,
	.target_on_host_o, .target_on_link_zero_o, .mgmt_link_zero_en_o, .mgmt_link_one_en_o,
	.sensor_hub_out_o, .sensor_hub_oe_o);

// ---- verif/tb.sv ----
`timescale 1ns/100ps
module tb;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00, h, sensor_hub_out_o, sensor_hub_oe_o;
	logic [3:0] wb_sel_i = 4'hf, v;
	logic [31:0] wb_dat_i = 32'h0, q, wb_dat_o;
	logic intruder_n_i = 1'b1, smbus_alert_n_i = 1'b1, battery_low_in_n_i = 1'b1;
	logic power_failure_event_i = 1'b0, deep_sleep_i = 1'b0, host_error_i = 1'b0, run = 1'b0;
	logic mgmt_link_zero_clk_i, wb_ack_o, mgmt_mode_interrupt_o, control_interrupt_o;
	logic system_error_signal_o, management_watchdog_unit_irq_o, system_reset_req_o;
	logic msg_valid_o, target_on_host_o, target_on_link_zero_o, mgmt_link_zero_en_o;
	logic mgmt_link_one_en_o, link_zero_fast_o, link_zero_phy_o;
	logic [2:0] msg_code_o;
	int bad_count = 0, checks_done = 0, cyc = 0, seed = 32'hc918f522;
	int cnt[5] = '{default: 0}, ex[5] = '{default: 0}, ms[$], em[$];
	// short counts keep the watchdog run brief
	wdt_event_mgr #(.TICK_CYCLES(4), .SECOND_TICKS(2)) i_dut (.clk_i, .rst_i, .wb_cyc_i,
		.wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .intruder_n_i,
		.smbus_alert_n_i, .battery_low_in_n_i, .power_failure_event_i, .deep_sleep_i,
		.mgmt_link_zero_clk_i, .host_error_i, .mgmt_mode_interrupt_o, .control_interrupt_o,
		.system_error_signal_o, .management_watchdog_unit_irq_o, .system_reset_req_o,
		.msg_valid_o, .msg_code_o, .target_on_host_o, .target_on_link_zero_o,
		.mgmt_link_zero_en_o, .mgmt_link_one_en_o, .link_zero_fast_o, .link_zero_phy_o,
		.sensor_hub_out_o, .sensor_hub_oe_o);
	link_partner i_link (.run_i(run), .clk_o(mgmt_link_zero_clk_i));
	initial begin
		forever #5 clk_i = ~clk_i;
	end
	// ------------------------------------------------------------
	// monitor and timeout
	// ------------------------------------------------------------
	always @(posedge clk_i) begin
		if (!rst_i) begin
			cnt[0] += mgmt_mode_interrupt_o;
			cnt[1] += control_interrupt_o;
			cnt[2] += system_error_signal_o;
			cnt[3] += management_watchdog_unit_irq_o;
			cnt[4] += system_reset_req_o;
			if (msg_valid_o === 1'b1) ms.push_back(int'(msg_code_o));
		end
	end
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			$display("Error timeout expected end seen hang");
			conclude();
		end
	end
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic wt(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			bad_count++;
			$display("Error %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do begin
			@(posedge clk_i);
		end while (wb_ack_o !== 1'b1);
		chk("ack", 1, wb_ack_o);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic cmp(input string s);
		for (int j = 0; j < 5; j++) chk(s, ex[j], cnt[j]);
		chk(s, em.size(), ms.size());
		foreach (em[j]) chk(s, em[j], ms[j]);
		$display("test %s done", s);
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		wt(2);
		chk("oe in reset", 0, sensor_hub_oe_o);
		rst_i <= 1'b0;
		wt(8);
		ms.delete();
		chk("after reset", 9'h100, {target_on_host_o, sensor_hub_oe_o});
		wb(0, wdt_event_pkg::OFS_CTRL, 0);
		chk("ctrl", 0, q);
		wb(0, wdt_event_pkg::OFS_TIMEOUT, 0);
		chk("timeout", 32'(wdt_event_pkg::TIMEOUT_RESET), q);
		wb(1, 8'h20, 32'hffff_ffff);
		wb(0, 8'h20, 0);
		chk("unmapped", 0, q);
		for (int i = 0; i < 4; i++) begin
			v = (i < 2) ? 4'h3 >> i : 4'($random(seed));
			wb(1, wdt_event_pkg::OFS_CTRL, {28'h0, v});
			wt(3);
			chk("links", {v[0] & v[1], ~(v[0] & v[1]), v[0], v[0], v[2], v[3]},
				{target_on_link_zero_o, target_on_host_o, mgmt_link_zero_en_o,
				mgmt_link_one_en_o, link_zero_fast_o, link_zero_phy_o});
		end
		$display("test modes done");
		wb(1, wdt_event_pkg::OFS_CTRL, 32'h5);
		run <= 1'b1;
		wt(100);
		run <= 1'b0;
		wt(4);
		wb(0, wdt_event_pkg::OFS_STATUS, 0);
		chk("overspeed", 1, q[4]);
		wb(0, wdt_event_pkg::OFS_LINK0_PERIOD, 0);
		chk("period", 8, q[15:0]);
		wb(1, wdt_event_pkg::OFS_STATUS, 32'h1f);
		wb(0, wdt_event_pkg::OFS_STATUS, 0);
		chk("overspeed clear", 0, q[4]);
		wb(1, wdt_event_pkg::OFS_TIMEOUT, 2);
		wb(1, wdt_event_pkg::OFS_CTRL, 32'h20);
		wt(40);
		ex[0]++;
		ex[4]++;
		em.push_back(1);
		cmp("watchdog");
		wb(0, wdt_event_pkg::OFS_STATUS, 0);
		chk("stage done", 3, q[9:8]);
		wb(1, wdt_event_pkg::OFS_CTRL, 32'h30);
		wb(1, wdt_event_pkg::OFS_RELOAD, 0);
		wt(40);
		ex[0]++;
		em.push_back(1);
		cmp("no reboot");
		repeat (8) wb(1, wdt_event_pkg::OFS_RELOAD, 0);
		wb(1, wdt_event_pkg::OFS_CTRL, 0);
		wt(40);
		cmp("reload");
		for (int i = 0; i < 6; i++) begin
			v = (i < 4) ? 4'h1 << i : ((i == 4) ? 4'h0 : 4'hf);
			wb(1, wdt_event_pkg::OFS_CTRL, {20'h0, v, 8'h0});
			host_error_i <= 1'b1;
			@(posedge clk_i);
			host_error_i <= 1'b0;
			wt(4);
			for (int j = 0; j < 4; j++) ex[j] += v[j];
		end
		cmp("errors");
		for (int i = 0; i < 2; i++) begin
			wb(1, wdt_event_pkg::OFS_CTRL, 32'(i) << 6);
			intruder_n_i <= 1'b0;
			wt(10);
			intruder_n_i <= 1'b1;
			wt(10);
			ex[(i == 1) ? 0 : 3]++;
			em.push_back(0);
		end
		cmp("intruder");
		smbus_alert_n_i <= 1'b0;
		wt(10);
		smbus_alert_n_i <= 1'b1;
		wt(10);
		battery_low_in_n_i <= 1'b0;
		wt(10);
		battery_low_in_n_i <= 1'b1;
		wt(10);
		power_failure_event_i <= 1'b1;
		wt(10);
		power_failure_event_i <= 1'b0;
		wt(10);
		em = {em, 2, 3, 4, 5, 6};
		cmp("messages");
		h = 8'($random(seed));
		wb(1, wdt_event_pkg::OFS_HUB_OUT, {24'h0, h});
		wb(1, wdt_event_pkg::OFS_CTRL, 32'h1000);
		wt(4);
		chk("hub on", {h, 8'hff}, {sensor_hub_out_o, sensor_hub_oe_o});
		deep_sleep_i <= 1'b1;
		wt(5);
		chk("hub sleep", 0, {sensor_hub_out_o, sensor_hub_oe_o});
		deep_sleep_i <= 1'b0;
		$display("test hub done");
		conclude();
	end
endmodule
